// File: abu_address_breakpoint_unit.v
`timescale 1ns/1ps
`include "abu_defines.vh"

// Function
// - enabled break and cpu program address equal to break address raises breakpoint request.
// - writing one to break active flag while it reads zero starts break without address match.
// - during break, status clearing allowed only with flag clear enable set.
// - break state halts the timer counter.
// - watchdog disabled during break in monitor mode when watchdog disable set.
// - break enable gates the full sixteen bit address comparison.
// - break enable at bit 7, read/write, clear by writing zero, resets zero.
// - active flag set on match, cleared by writing zero, resets zero.
// - break address held as high and low byte registers, reset to zero.
module abu_address_breakpoint_unit (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  input  wire [15:0] cpu_addr_i,
  input  wire        cpu_fetch_i,
  input  wire        return_from_interrupt_i,
  input  wire        monitor_mode_i,
  input  wire        wait_exit_i,
  input  wire        status_clear_req_i,
  output wire        breakpoint_request_o,
  output wire        break_state_o,
  output wire        status_clear_allow_o,
  output wire        timer_halt_o,
  output wire        watchdog_disable_o,
  output wire        irq_o
);

  // ----------------------------------------
  // state encoding
  // ----------------------------------------
  localparam       ST_RUN   = 1'b0;
  localparam       ST_BREAK = 1'b1;
  localparam       IRQ_N    = 3;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg        brk_en_r;
  reg        brk_en_nxt;
  reg        brk_act_r;
  reg        brk_act_nxt;
  reg  [7:0] addr_hi_r;
  reg  [7:0] addr_hi_nxt;
  reg  [7:0] addr_lo_r;
  reg  [7:0] addr_lo_nxt;
  reg        wdog_dis_r;
  reg        wdog_dis_nxt;
  reg        clr_en_r;
  reg        clr_en_nxt;
  reg        wait_exit_r;
  reg        wait_exit_nxt;
  reg        state_r;
  reg        state_nxt;
  reg  [2:0] irq_stat_r;
  wire [2:0] irq_stat_nxt;
  reg  [2:0] irq_mask_r;
  reg  [2:0] irq_mask_nxt;
  wire       in_break;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       lane0    = wb_sel_i[0];
  wire       hit      = (wb_adr_i[31:5] == 27'h0) & (wb_adr_i[1:0] == 2'h0) &
                        (wb_adr_i[4:2] <= 3'h7);
  wire [3:0] idx      = {1'b0, wb_adr_i[4:2]};
  wire       wr       = req & wb_we_i & lane0 & hit;
  wire       wr_sc    = wr & (idx == `ABU_OFS_STATUS_CONTROL);
  wire       wr_hi    = wr & (idx == `ABU_OFS_ADDR_HIGH);
  wire       wr_lo    = wr & (idx == `ABU_OFS_ADDR_LOW);
  wire       wr_aux   = wr & (idx == `ABU_OFS_AUXILIARY);
  wire       wr_sr    = wr & (idx == `ABU_OFS_STATUS_REG);
  wire       wr_fc    = wr & (idx == `ABU_OFS_FLAG_CONTROL);
  wire       wr_is    = wr & (idx == `ABU_OFS_IRQ_STATUS);
  wire       wr_im    = wr & (idx == `ABU_OFS_IRQ_MASK);
  wire [7:0] wd       = wb_dat_i[7:0];

  // ----------------------------------------
  // break detection
  // ----------------------------------------
  wire       addr_eq   = (cpu_addr_i == {addr_hi_r, addr_lo_r});
  wire       match     = brk_en_r & cpu_fetch_i & addr_eq;
  wire       soft_brk  = wr_sc & wd[`ABU_BIT_ACTIVE] & ~brk_act_r;
  wire       brk_start = match | soft_brk;

  // ----------------------------------------
  // event vector
  // ----------------------------------------
  assign in_break = (state_r == ST_BREAK);
  wire       rti_seen  = in_break & return_from_interrupt_i;
  wire [2:0] ev        = {rti_seen, soft_brk, match};

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign breakpoint_request_o = brk_start;
  assign break_state_o        = in_break;
  assign status_clear_allow_o = status_clear_req_i & (~in_break | clr_en_r);
  assign timer_halt_o         = in_break;
  assign watchdog_disable_o   = in_break & monitor_mode_i & wdog_dis_r;
  assign irq_o                = |(irq_stat_r & irq_mask_r);
  assign wb_err_o             = 1'b0;

  // ----------------------------------------
  // break state machine
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (brk_start) begin
          state_nxt = ST_BREAK;
        end
      end
      ST_BREAK: begin
        if (brk_start) begin
          state_nxt = ST_BREAK;
        end else if (return_from_interrupt_i) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // next register values
  // ----------------------------------------
  always @* begin
    brk_en_nxt = brk_en_r;
    if (wr_sc) begin
      brk_en_nxt = wd[`ABU_BIT_ENABLE];
    end
  end

  always @* begin
    brk_act_nxt = brk_act_r;
    if (brk_start) begin
      brk_act_nxt = 1'b1;
    end else if (wr_sc & ~wd[`ABU_BIT_ACTIVE]) begin
      brk_act_nxt = 1'b0;
    end
  end

  always @* begin
    addr_hi_nxt = addr_hi_r;
    if (wr_hi) begin
      addr_hi_nxt = wd;
    end
  end

  always @* begin
    addr_lo_nxt = addr_lo_r;
    if (wr_lo) begin
      addr_lo_nxt = wd;
    end
  end

  always @* begin
    wdog_dis_nxt = wdog_dis_r;
    if (wr_aux) begin
      wdog_dis_nxt = wd[`ABU_BIT_WDOG_DISABLE];
    end
  end

  always @* begin
    clr_en_nxt = clr_en_r;
    if (wr_fc) begin
      clr_en_nxt = wd[`ABU_BIT_CLEAR_ENABLE];
    end
  end

  always @* begin
    wait_exit_nxt = wait_exit_r;
    if (in_break & wait_exit_i) begin
      wait_exit_nxt = 1'b1;
    end else if (wr_sr & ~wd[`ABU_BIT_WAIT_EXIT]) begin
      wait_exit_nxt = 1'b0;
    end
  end

  always @* begin
    irq_mask_nxt = irq_mask_r;
    if (wr_im) begin
      irq_mask_nxt = wd[2:0];
    end
  end

  // ----------------------------------------
  // sticky interrupt bits, set wins
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < IRQ_N; g = g + 1) begin : g_irq
      assign irq_stat_nxt[g] = ev[g] | (irq_stat_r[g] & ~(wr_is & wd[g]));
    end
  endgenerate

  // ----------------------------------------
  // register flops
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      brk_en_r <= 1'b0;
    end else begin
      brk_en_r <= brk_en_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      brk_act_r <= 1'b0;
    end else begin
      brk_act_r <= brk_act_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_hi_r <= `ABU_RST_BYTE;
    end else begin
      addr_hi_r <= addr_hi_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_lo_r <= `ABU_RST_BYTE;
    end else begin
      addr_lo_r <= addr_lo_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wdog_dis_r <= 1'b0;
    end else begin
      wdog_dis_r <= wdog_dis_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      clr_en_r <= 1'b0;
    end else begin
      clr_en_r <= clr_en_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wait_exit_r <= 1'b0;
    end else begin
      wait_exit_r <= wait_exit_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= `ABU_RST_IRQ;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= `ABU_RST_IRQ;
    end else begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // ----------------------------------------
  // read data and acknowledge
  // ----------------------------------------
  reg [7:0] rd;
  always @* begin
    rd = 8'h00;
    case (idx)
      `ABU_OFS_STATUS_CONTROL: rd = {brk_en_r, brk_act_r, 6'h00};
      `ABU_OFS_ADDR_HIGH:      rd = addr_hi_r;
      `ABU_OFS_ADDR_LOW:       rd = addr_lo_r;
      `ABU_OFS_AUXILIARY:      rd = {6'h00, wdog_dis_r, 1'b0};
      `ABU_OFS_STATUS_REG:     rd = {6'h00, wait_exit_r, 1'b0};
      `ABU_OFS_FLAG_CONTROL:   rd = {clr_en_r, 7'h00};
      `ABU_OFS_IRQ_STATUS:     rd = {5'h00, irq_stat_r};
      `ABU_OFS_IRQ_MASK:       rd = {5'h00, irq_mask_r};
      default:                 rd = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        wb_dat_o <= hit ? {24'h000000, rd} : 32'h0;
      end
    end
  end

endmodule // abu_address_breakpoint_unit

// File: abu_defines.vh
`ifndef ABU_DEFINES_VH
`define ABU_DEFINES_VH

// ----------------------------------------
// register offsets (word indices; byte address is offset times four)
// ----------------------------------------
`define ABU_OFS_STATUS_CONTROL 4'h0
`define ABU_OFS_ADDR_HIGH      4'h1
`define ABU_OFS_ADDR_LOW       4'h2
`define ABU_OFS_AUXILIARY      4'h3
`define ABU_OFS_STATUS_REG     4'h4
`define ABU_OFS_FLAG_CONTROL   4'h5
`define ABU_OFS_IRQ_STATUS     4'h6
`define ABU_OFS_IRQ_MASK       4'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define ABU_BIT_ENABLE         7
`define ABU_BIT_ACTIVE         6
`define ABU_BIT_WDOG_DISABLE   1
`define ABU_BIT_CLEAR_ENABLE   7
`define ABU_BIT_WAIT_EXIT      1
`define ABU_IRQ_MATCH          0
`define ABU_IRQ_SOFT           1
`define ABU_IRQ_END            2

// ----------------------------------------
// reset values
// ----------------------------------------
`define ABU_RST_BYTE           8'h00
`define ABU_RST_IRQ            3'h0

`endif

// File: abu_cpu_model.sv
`timescale 1ns/1ps
module abu_cpu_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        breakpoint_request_i,
  input  wire        mon_i,
  output reg  [15:0] pc_o,
  output reg         rti_o
);
  reg [5:0] n_r;
  always @(posedge clk_i) begin
    rti_o <= 1'b0;
    if (rst_i) begin
      pc_o <= 16'h0000;
      n_r <= 6'h00;
    end else if (n_r != 6'h00) begin
      n_r <= n_r - 6'h01;
      rti_o <= (n_r == 6'h01);
    end else if (breakpoint_request_i) begin
      n_r <= 6'h3f;
      pc_o <= mon_i ? 16'hfefc : 16'hfffc;
    end else
      pc_o <= pc_o + 16'h0001;
  end
endmodule // abu_cpu_model

// File: abu_address_breakpoint_unit_props.sv
`timescale 1ns/1ps
module abu_props (
  input wire clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, cpu_fetch_i,
  input wire return_from_interrupt_i, monitor_mode_i, status_clear_req_i,
  input wire breakpoint_request_o, break_state_o, status_clear_allow_o,
  input wire timer_halt_o, watchdog_disable_o, irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i & wb_stb_i;
  wire bs = break_state_o;
  property p_ack; req & !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ent; breakpoint_request_o & !bs |=> bs; endproperty
  a_ent: assert property (p_ent) else $error("no break entry");
  property p_hold; bs & !return_from_interrupt_i |=> bs; endproperty
  a_hold: assert property (p_hold) else $error("break lost");
  property p_exit; return_from_interrupt_i & !breakpoint_request_o |=> !bs; endproperty
  a_exit: assert property (p_exit) else $error("break kept");
  property p_tmr; timer_halt_o == bs; endproperty
  a_tmr: assert property (p_tmr) else $error("timer halt wrong");
  property p_wd; watchdog_disable_o |-> bs & monitor_mode_i; endproperty
  a_wd: assert property (p_wd) else $error("watchdog off");
  property p_clr; !bs |-> status_clear_allow_o == status_clear_req_i; endproperty
  a_clr: assert property (p_clr) else $error("clear gate wrong");
  property p_src; breakpoint_request_o |-> cpu_fetch_i | (req & wb_we_i); endproperty
  a_src: assert property (p_src) else $error("bad request");
  property p_irq; $fell(irq_o) |-> $past(req & wb_we_i); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped");
  c_mon: cover property (bs & monitor_mode_i);
  c_irq: cover property (irq_o);
  c_end: cover property (bs & return_from_interrupt_i);
endmodule // abu_props
bind abu_address_breakpoint_unit abu_props i_props (.*);

// File: test_address_breakpoint_unit.sv
`timescale 1ns/1ps
module test_address_breakpoint_unit;
  reg clk_i = 0, rst_i = 1, we = 0, cyc = 0, mon = 0, scr = 0, fx = 1, wx = 0;
  reg [15:0] dadr = 0;
  reg [31:0] adr = 0, dat = 0;
  wire [31:0] rd;
  wire [15:0] pc;
  wire ack, bk, st, al, th, wd, irq, return_from_interrupt_opcode;
  integer err_total = 0, check_count = 0, seed = 84, i;
  logic [7:0] q[$];
  reg [15:0] ba;
  always #20 clk_i = ~clk_i;
  abu_address_breakpoint_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_dat_o(rd), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_ack_o(ack), .wb_err_o(), .cpu_addr_i(fx ? pc : dadr),
    .cpu_fetch_i(fx),
    .return_from_interrupt_i(return_from_interrupt_opcode), .monitor_mode_i(mon), .wait_exit_i(wx),
    .status_clear_req_i(scr), .breakpoint_request_o(bk), .break_state_o(st),
    .status_clear_allow_o(al), .timer_halt_o(th), .watchdog_disable_o(wd), .irq_o(irq));
  abu_cpu_model i_cpu (.clk_i(clk_i), .rst_i(rst_i), .breakpoint_request_i(bk), .mon_i(mon), .pc_o(pc),
    .rti_o(return_from_interrupt_opcode));
  task chk(input string n, input [7:0] s, input [7:0] e);
    check_count = check_count + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task wb(input [3:0] ix, input w, input [7:0] d);
    @(posedge clk_i);
    adr <= {26'h0, ix, 2'b00};
    we <= w;
    dat <= {24'h0, d};
    cyc <= 1;
    @(posedge clk_i);
    while (!ack) @(posedge clk_i);
    cyc <= 0;
  endtask
  task rdq(input [3:0] ix, input [7:0] e);
    q.push_back(e);
    wb(ix, 0, 8'h00);
  endtask
  task wst(input v);
    repeat (300) if (st !== v) @(posedge clk_i);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) if (ack && !we) chk("read", rd[7:0], q.pop_front());
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    for (i = 0; i < 9; i = i + 1) rdq(i, 8'h00);
    ba = 16'h0080 + ($random(seed) & 16'h003f);
    wb(1, 1, ba[15:8]);
    wb(2, 1, ba[7:0]);
    rdq(1, ba[15:8]);
    rdq(2, ba[7:0]);
    wb(3, 1, 8'h02);
    wb(0, 1, 8'h80);
    rdq(0, 8'h80);
    mon <= 1;
    scr <= 1;
    wst(1);
    chk("state", {4'h0, st, th, wd, al}, 8'h0e);
    wx <= 1;
    @(posedge clk_i);
    wx <= 0;
    rdq(4, 8'h02);
    wb(4, 1, 8'h00);
    rdq(4, 8'h00);
    rdq(0, 8'hc0);
    wb(0, 1, 8'h80);
    rdq(0, 8'h80);
    wb(5, 1, 8'h80);
    @(posedge clk_i);
    chk("allow", {7'h0, al}, 8'h01);
    wst(0);
    chk("exit", {7'h0, st}, 8'h00);
    rdq(6, 8'h05);
    wb(7, 1, 8'h07);
    @(posedge clk_i);
    chk("irq", {7'h0, irq}, 8'h01);
    wb(6, 1, 8'h07);
    @(posedge clk_i);
    chk("irq", {7'h0, irq}, 8'h00);
    mon <= 0;
    wb(0, 1, 8'h40);
    wst(1);
    chk("soft", {6'h0, st, wd}, 8'h02);
    wst(0);
    wb(0, 1, 8'h00);
    wb(6, 1, 8'h07);
    ba = pc + 16'h0020;
    wb(1, 1, ba[15:8]);
    wb(2, 1, ba[7:0]);
    repeat (64) @(posedge clk_i);
    rdq(6, 8'h00);
    dadr <= ba;
    fx <= 0;
    wb(0, 1, 8'h80);
    repeat (8) @(posedge clk_i);
    chk("data", {7'h0, st}, 8'h00);
    rdq(6, 8'h00);
    wrap_up;
  end
  initial begin
    #400000;
    err_total = err_total + 1;
    wrap_up;
  end
endmodule // test_address_breakpoint_unit
